// *** sld_pkg.sv ***
// sld_pkg: constants and carrier types for the serial latched driver control block
// assumes a 250 MHz ref_clk sampling all pins
package sld_pkg;
	localparam int SLD_CHANNELS = 8;
	localparam int SLD_CLK_PERIOD_PS = 4000;
	localparam int SLD_OC_FILTER_NS = 2000;
	localparam int SLD_OC_FILTER_CYC = (SLD_OC_FILTER_NS * 1000) / SLD_CLK_PERIOD_PS;
	localparam int SLD_OC_CNT_W = 10;
	localparam logic [7:0] SLD_ZERO8 = 8'h00;
	localparam logic SLD_SHIFT_FILL_CLR = 1'h0;

	typedef struct packed {
		logic ser_in;
		logic shift_clk;
		logic clear;
		logic strobe;
		logic disable_reset;
	} sld_ctrl_t;
endpackage : sld_pkg

// *** sld_driver_ctrl.sv ***
// sld_driver_ctrl: shift register, latches, output gating and fault logic
// assumes control pins and fault sensors are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module sld_driver_ctrl import sld_pkg::*; #(
	parameter int CH = SLD_CHANNELS,
	parameter int OC_FILTER = SLD_OC_FILTER_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire sld_ctrl_t ctrl_pins,
	input wire logic [CH-1:0] overcurrent_sense,
	input wire logic over_temp,
	input wire logic supply_undervoltage_lockout,
	output logic ser_out_reg,
	output logic [CH-1:0] drive_on_reg,
	output logic fault_flag_oe_reg,
	output logic fault_flag_o_reg,
	output logic [CH-1:0] latch_out_reg,
	output logic [CH-1:0] oc_tripped_reg
);
	// ************************************************
	// input synchronisers
	// ************************************************
	localparam int SW = 5 + CH + 2;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	logic shclk_d_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			shclk_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {ctrl_pins, overcurrent_sense, over_temp, supply_undervoltage_lockout};
			sync2_reg <= sync1_reg;
			shclk_d_reg <= sync2_reg[SW-2];
		end
	end
	logic s_din, s_clk, s_clr, s_stb, s_dis, s_ot, s_uv;
	logic [CH-1:0] s_oc;
	assign s_din = sync2_reg[SW-1];
	assign s_clk = sync2_reg[SW-2];
	assign s_clr = sync2_reg[SW-3];
	assign s_stb = sync2_reg[SW-4];
	assign s_dis = sync2_reg[SW-5];
	assign s_oc = sync2_reg[CH+1:2];
	assign s_ot = sync2_reg[1];
	assign s_uv = sync2_reg[0];
	logic shift_edge;
	assign shift_edge = s_clk && !shclk_d_reg;
	logic eff_dis;
	assign eff_dis = s_dis || s_uv;

	// ************************************************
	// shift register
	// ************************************************
	logic [CH-1:0] shift_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shift_reg <= '0;
		end else if (shift_edge) begin
			shift_reg <= {shift_reg[CH-2:0], s_clr ? SLD_SHIFT_FILL_CLR : s_din};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ser_out_reg <= 1'b0;
		end else if (shift_edge) begin
			ser_out_reg <= shift_reg[CH-2];
		end
	end

	// ************************************************
	// output latches
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			latch_out_reg <= '0;
		end else if (s_stb) begin
			latch_out_reg <= shift_reg;
		end
	end

	// ************************************************
	// overcurrent filter and latch
	// ************************************************
	logic dis_d_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dis_d_reg <= 1'b0;
		end else begin
			dis_d_reg <= s_dis;
		end
	end
	logic fault_reset;
	assign fault_reset = dis_d_reg && !s_dis;
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_oc
			logic [SLD_OC_CNT_W-1:0] cnt_reg;
			logic trip;
			assign trip = s_oc[g] && (cnt_reg == SLD_OC_CNT_W'(OC_FILTER - 1));
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					cnt_reg <= '0;
				end else if (!s_oc[g]) begin
					cnt_reg <= '0;
				end else if (!trip) begin
					cnt_reg <= cnt_reg + SLD_OC_CNT_W'(1);
				end
			end
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					oc_tripped_reg[g] <= 1'b0;
				end else if (trip) begin
					oc_tripped_reg[g] <= 1'b1;
				end else if (fault_reset) begin
					oc_tripped_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ************************************************
	// drivers and flag
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drive_on_reg <= '0;
		end else if (eff_dis || s_ot) begin
			drive_on_reg <= '0;
		end else begin
			drive_on_reg <= latch_out_reg & ~oc_tripped_reg;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fault_flag_oe_reg <= 1'b0;
			fault_flag_o_reg <= 1'b0;
		end else begin
			fault_flag_oe_reg <= (|oc_tripped_reg) || s_ot;
			fault_flag_o_reg <= 1'b0;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!s_stb |=> $stable(latch_out_reg)) else $error("latch changed with strobe low");
	AST_LATCH_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_stb |=> latch_out_reg == $past(shift_reg)) else $error("latch not following");
	AST_SHIFT_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!shift_edge |=> $stable(shift_reg) && $stable(ser_out_reg)) else $error("shift moved");
	AST_SHIFT_IN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		shift_edge && !s_clr |=> shift_reg[0] == $past(s_din)) else $error("data not captured");
	AST_CLEAR_IN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		shift_edge && s_clr |=> !shift_reg[0]) else $error("clear did not load zero");
	AST_SHIFT_MOVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		shift_edge |=> shift_reg[CH-1:1] == $past(shift_reg[CH-2:0])) else $error("no shift");
	AST_DISABLE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		eff_dis |=> drive_on_reg == '0) else $error("driver on while disabled");
	AST_DRIVE_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!eff_dis && !s_ot && oc_tripped_reg == '0 |=> drive_on_reg == $past(latch_out_reg))
		else $error("driver not following latch");
	AST_OT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_ot |=> drive_on_reg == '0 && fault_flag_oe_reg) else $error("overtemp not handled");
	AST_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(|oc_tripped_reg) |=> fault_flag_oe_reg) else $error("flag not pulled on trip");
	AST_UV: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_uv |=> drive_on_reg == '0) else $error("driver on in undervoltage");
	AST_OC_SHORT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!s_oc[0] ##1 s_oc[0] [*8] |-> !g_oc[0].trip) else $error("short pulse tripped");
	AST_OC_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fault_reset && !g_oc[0].trip |=> !oc_tripped_reg[0])
		else $error("reset pulse did not clear trip");
	AST_OC_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		g_oc[0].trip |=> oc_tripped_reg[0] ##1 !drive_on_reg[0]) else $error("trip not held");
endmodule : sld_driver_ctrl
`default_nettype wire

// *** sld_ctrl_model.sv ***
// sld_ctrl_model: controller that shifts bytes into the driver
// assumes ref_clk at 250 MHz; shift clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl_model import sld_pkg::*; (
	input wire logic ref_clk,
	output sld_ctrl_t pins
);
	initial pins = '0;
	task automatic send(input logic [7:0] b, input logic clr);
		for (int i = 7; i >= 0; i--) begin
			@(posedge ref_clk);
			pins.ser_in <= b[i];
			pins.clear <= clr;
			repeat (15) @(posedge ref_clk);
			pins.shift_clk <= 1'h1;
			repeat (15) @(posedge ref_clk);
			pins.shift_clk <= 1'h0;
		end
		pins.ser_in <= ~b[0];
		pins.clear <= 1'h0;
	endtask : send
	task automatic set(input logic stb, input logic dis);
		@(posedge ref_clk);
		pins.strobe <= stb;
		pins.disable_reset <= dis;
	endtask : set
endmodule : sld_ctrl_model
`default_nettype wire

// *** serial_latched_driver_control_tb_top.sv ***
// serial_latched_driver_control_tb_top: self-checking bench
// assumes sld_driver_ctrl and sld_ctrl_model compiled first
`timescale 1ns/1ps
`default_nettype none
module serial_latched_driver_control_tb_top import sld_pkg::*; ;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	sld_ctrl_t pins;
	logic [7:0] oc = 8'h00;
	logic ot = 1'h0;
	logic uv = 1'h0;
	logic smp = 1'h0;
	logic so, foe, fo;
	logic [7:0] drv, lat, trip, b, b2;
	logic [26:0] expq[$];
	int mismatches = 0;
	int check_count = 0;
	int seed = 24;
	int k;
	always #2 ref_clk = ~ref_clk;
	sld_ctrl_model ctl (.ref_clk(ref_clk), .pins(pins));
	sld_driver_ctrl #(.OC_FILTER(20)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.ctrl_pins(pins), .overcurrent_sense(oc), .over_temp(ot),
		.supply_undervoltage_lockout(uv), .ser_out_reg(so), .drive_on_reg(drv),
		.fault_flag_oe_reg(foe), .fault_flag_o_reg(fo), .latch_out_reg(lat),
		.oc_tripped_reg(trip));
	// ****************
	// checking
	// ****************
	task automatic expect_out(input logic [26:0] x);
		expq.push_back(x);
		repeat (8) @(posedge ref_clk);
		smp <= 1'h1;
		@(posedge ref_clk);
		smp <= 1'h0;
	endtask : expect_out
	task automatic cmp_out(input logic [26:0] got, input logic [26:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_out
	always @(posedge ref_clk) if (smp) cmp_out({so, foe, fo, trip, lat, drv}, expq.pop_front());
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		complete_run();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		b = 8'($random(seed));
		b2 = 8'($random(seed));
		k = {$random(seed)} % 8;
		ctl.send(b, 1'h0);
		ctl.set(1'h1, 1'h0);
		expect_out({b[7], 1'h0, 1'h0, 8'h00, b, b});
		ctl.set(1'h0, 1'h0);
		ctl.send(b2, 1'h0);
		expect_out({b2[7], 1'h0, 1'h0, 8'h00, b, b});
		ctl.set(1'h1, 1'h1);
		expect_out({b2[7], 1'h0, 1'h0, 8'h00, b2, 8'h00});
		ctl.set(1'h1, 1'h0);
		expect_out({b2[7], 1'h0, 1'h0, 8'h00, b2, b2});
		ctl.set(1'h1, 1'h1);
		ctl.send(8'hFF, 1'h1);
		expect_out({27'h0000000});
		ctl.send(8'hFF, 1'h0);
		ctl.set(1'h1, 1'h0);
		$display("shift tests done");
		oc[k] <= 1'h1;
		repeat (10) @(posedge ref_clk);
		oc[k] <= 1'h0;
		expect_out({2'h2, 1'h0, 8'h00, 8'hFF, 8'hFF});
		oc[k] <= 1'h1;
		repeat (30) @(posedge ref_clk);
		oc[k] <= 1'h0;
		expect_out({2'h3, 1'h0, 8'h01 << k, 8'hFF, 8'hFF & ~(8'h01 << k)});
		ctl.set(1'h1, 1'h1);
		ctl.set(1'h1, 1'h0);
		expect_out({2'h2, 1'h0, 8'h00, 8'hFF, 8'hFF});
		ot <= 1'h1;
		expect_out({2'h3, 1'h0, 8'h00, 8'hFF, 8'h00});
		ot <= 1'h0;
		expect_out({2'h2, 1'h0, 8'h00, 8'hFF, 8'hFF});
		uv <= 1'h1;
		expect_out({2'h2, 1'h0, 8'h00, 8'hFF, 8'h00});
		uv <= 1'h0;
		expect_out({2'h2, 1'h0, 8'h00, 8'hFF, 8'hFF});
		$display("fault tests done");
		complete_run();
	end
endmodule : serial_latched_driver_control_tb_top
`default_nettype wire
